// ---- gpio_ports_pkg.sv ----
// Package: register map, reset values and bus carriers for the four-port line block
package gpio_ports_pkg;

  localparam int num_ports = 4;
  localparam int port_width = 8;

  // Register offsets are word indices; the byte address on the bus is index times four
  localparam logic [7:0] port0_line_levels_idx = 8'h78;
  localparam logic [7:0] port1_line_levels_idx = 8'h79;
  localparam logic [7:0] port2_line_levels_idx = 8'h7A;
  localparam logic [7:0] port3_line_levels_idx = 8'h7B;
  localparam logic [7:0] port0_line_directions_idx = 8'h98;
  localparam logic [7:0] port1_line_directions_idx = 8'h99;
  localparam logic [7:0] port2_line_directions_idx = 8'h9A;
  localparam logic [7:0] port3_line_directions_idx = 8'h9B;
  localparam int addr_width = 10;

  // Values after reset
  localparam logic [7:0] levels_reset = 8'h00;
  localparam logic [7:0] dir_reset_port0 = 8'h20;
  localparam logic [7:0] dir_reset_port1 = 8'h70;
  localparam logic [7:0] dir_reset_port2 = 8'h00;
  localparam logic [7:0] dir_reset_port3 = 8'h00;

  // Named line positions
  localparam int sensor_irq_line = 3;
  localparam int video_sleep_line = 5;
  localparam int wd_kick_line = 7;
  localparam int wd_fired_line = 0;
  localparam int usb_prot_line = 2;
  localparam int xcvr_fault_line = 3;
  localparam int term_first_line = 4;
  localparam int term_second_line = 5;
  localparam int wd_enable_line = 6;
  localparam int flash_en_line = 7;
  localparam int battery_line = 6;
  localparam int wd_clear_line = 7;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [addr_width-1:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef struct packed {
    logic sensor_irq;
    logic wd_fired_n;
    logic usb_prot_ok_n;
    logic xcvr_fault;
    logic battery_ok;
  } board_status_type;

endpackage

// ---- gpio_ports.sv ----
// Four eight-line ports with level and direction registers on classic Wishbone
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns

// What this block does
// - Four ports of eight lines, each line set input or output by software.
// - Each port has one 8-bit level register and one 8-bit direction register.
// - Level register bit n maps to line n, bit 0 to line 0.
// - Direction bit n set to 0 makes line n input, 1 makes it output.
// - All lines of port two come out of reset as inputs.
// - Port zero line 3 is the sensor interrupt input, active high.
// - Port one line 0 reads 0 when the external watchdog fired.
// - Port one line 2 reads 0 when USB power protection tripped.
// - Port one line 3 reads 1 on a differential transceiver fault.
// - Port one lines 4 and 5 are terminator outputs; polarity unconfirmed.
// - Port three line 6 reads 0 when the backup battery needs replacing.
// - Port three line 7 resets as input; driving it clears watchdog and restarts.
// - Port zero line 5 puts the video processor into power saving.
module gpio_ports
  import gpio_ports_pkg::*;
#(
  parameter int ports = num_ports,
  parameter int width = port_width
)
(
  input wire logic clk,
  input wire logic rst,
  input wire wb_req_type wb_req,
  output wb_rsp_type wb_rsp,
  input wire logic [ports*width-1:0] line_in,
  output logic [ports*width-1:0] line_out,
  output logic [ports*width-1:0] line_oe,
  output board_status_type board_status
);

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic [2:0] decode(input logic [addr_width-1:0] adr);
    logic [7:0] idx;
    idx = adr[addr_width-1:2];
    case (idx)
      port0_line_levels_idx: decode = 3'b100;
      port1_line_levels_idx: decode = 3'b101;
      port2_line_levels_idx: decode = 3'b110;
      port3_line_levels_idx: decode = 3'b111;
      default: decode = 3'b000;
    endcase
  endfunction

  function automatic logic [2:0] decode_dir(input logic [addr_width-1:0] adr);
    logic [7:0] idx;
    idx = adr[addr_width-1:2];
    case (idx)
      port0_line_directions_idx: decode_dir = 3'b100;
      port1_line_directions_idx: decode_dir = 3'b101;
      port2_line_directions_idx: decode_dir = 3'b110;
      port3_line_directions_idx: decode_dir = 3'b111;
      default: decode_dir = 3'b000;
    endcase
  endfunction

  function automatic logic [7:0] dir_reset(input int p);
    case (p)
      0: dir_reset = dir_reset_port0;
      1: dir_reset = dir_reset_port1;
      2: dir_reset = dir_reset_port2;
      default: dir_reset = dir_reset_port3;
    endcase
  endfunction

  // ==========================================================
  // Register state
  // ==========================================================
  logic [width-1:0] level_q [ports];
  logic [width-1:0] level_d [ports];
  logic [width-1:0] dir_q [ports];
  logic [width-1:0] dir_d [ports];
  logic [width-1:0] pin_q [ports];
  wb_rsp_type rsp_q;
  wb_rsp_type rsp_d;
  logic [ports*width-1:0] out_q;
  logic [ports*width-1:0] out_d;
  logic [ports*width-1:0] oe_q;
  logic [ports*width-1:0] oe_d;
  board_status_type stat_q;
  board_status_type stat_d;

  logic req;
  logic [2:0] lvl_hit;
  logic [2:0] dir_hit;
  logic [width-1:0] rd_val;

  assign req = wb_req.cyc && wb_req.stb && !rsp_q.ack && !rsp_q.err;
  assign lvl_hit = decode(wb_req.adr);
  assign dir_hit = decode_dir(wb_req.adr);

  always_comb
  begin
    rd_val = '0;
    for (int p = 0; p < ports; p++)
    begin
      level_d[p] = level_q[p];
      dir_d[p] = dir_q[p];
      // Only byte lane 0 carries data; other lanes are ignored
      if (req && wb_req.we && wb_req.sel[0])
      begin
        if (lvl_hit[2] && lvl_hit[1:0] == p[1:0])
        begin
          level_d[p] = wb_req.dat[width-1:0];
        end
        if (dir_hit[2] && dir_hit[1:0] == p[1:0])
        begin
          dir_d[p] = wb_req.dat[width-1:0];
        end
      end
      if (lvl_hit[2] && lvl_hit[1:0] == p[1:0])
      begin
        // Per-bit mux between pin and stored value
        rd_val = (dir_q[p] & level_q[p]) | (~dir_q[p] & pin_q[p]);
      end
      if (dir_hit[2] && dir_hit[1:0] == p[1:0])
      begin
        rd_val = dir_q[p];
      end
    end
  end

  always_comb
  begin
    rsp_d = '0;
    if (req)
    begin
      if (lvl_hit[2] || dir_hit[2])
      begin
        rsp_d.ack = 1'b1;
        rsp_d.dat = {24'h000000, rd_val};
      end
      else
      begin
        // Unmapped address: answer with err so the master never hangs
        rsp_d.err = 1'b1;
      end
    end
  end

  // ==========================================================
  // Pin drive and board status
  // ==========================================================
  always_comb
  begin
    for (int p = 0; p < ports; p++)
    begin
      // Writes to input lines are kept but not driven
      // Terminator and video sleep lines are plain stored outputs; polarity is software's
      out_d[p*width +: width] = level_q[p] & dir_q[p];
      oe_d[p*width +: width] = dir_q[p];
    end
    // Line n of port p is bit p*width+n of the flattened vector
    stat_d.sensor_irq = pin_q[0][sensor_irq_line];
    stat_d.wd_fired_n = pin_q[1][wd_fired_line];
    stat_d.usb_prot_ok_n = pin_q[1][usb_prot_line];
    stat_d.xcvr_fault = pin_q[1][xcvr_fault_line];
    stat_d.battery_ok = pin_q[3][battery_line];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < ports; p++)
      begin
        level_q[p] <= levels_reset;
        dir_q[p] <= dir_reset(p);
        pin_q[p] <= '0;
      end
      rsp_q <= '0;
      out_q <= '0;
      oe_q <= '0;
      stat_q <= '0;
    end
    else
    begin
      for (int p = 0; p < ports; p++)
      begin
        level_q[p] <= level_d[p];
        dir_q[p] <= dir_d[p];
        pin_q[p] <= line_in[p*width +: width];
      end
      rsp_q <= rsp_d;
      out_q <= out_d;
      oe_q <= oe_d;
      stat_q <= stat_d;
    end
  end

  assign wb_rsp = rsp_q;
  assign line_out = out_q;
  assign line_oe = oe_q;
  assign board_status = stat_q;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence dir_write_s(int p);
    req && wb_req.we && wb_req.sel[0] && dir_hit == {1'b1, 2'(p)};
  endsequence

  sequence lvl_write_s(int p);
    req && wb_req.we && wb_req.sel[0] && lvl_hit == {1'b1, 2'(p)};
  endsequence

  sequence lvl_read_s(int p);
    req && !wb_req.we && lvl_hit == {1'b1, 2'(p)};
  endsequence

  sequence dir_read_s(int p);
    req && !wb_req.we && dir_hit == {1'b1, 2'(p)};
  endsequence

  // One answer cycle, then a quiet one so a held request is not taken twice
  sequence answer_s;
    (rsp_q.ack || rsp_q.err) ##1 !(rsp_q.ack || rsp_q.err);
  endsequence

  // Reset directions reach the enables one edge after release
  port2_reset_in_a: assert property (@(posedge clk)
    $fell(rst) |=> oe_q[23:16] == 8'h00)
    else $error("port two not input after reset");
  p3_l7_reset_a: assert property (@(posedge clk)
    $fell(rst) |=> !oe_q[31])
    else $error("port three line 7 driven after reset");

  // Bus answers
  write_one_ack_a: assert property (@(posedge clk) disable iff (rst)
    req |=> answer_s)
    else $error("bus answer not single cycle");
  unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
    req && !lvl_hit[2] && !dir_hit[2] |=> rsp_q.err && !rsp_q.ack)
    else $error("unmapped access not refused");
  rsp_upper_a: assert property (@(posedge clk) disable iff (rst)
    rsp_q.dat[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // Register writes and reads
  dir_to_oe_a: assert property (@(posedge clk) disable iff (rst)
    dir_write_s(1) |=> ##1 oe_q[15:8] == $past(wb_req.dat[7:0], 2))
    else $error("direction write not reflected on enables");
  p3_l7_drive_a: assert property (@(posedge clk) disable iff (rst)
    dir_write_s(3) |=> ##1 oe_q[31] == $past(wb_req.dat[7], 2))
    else $error("port three line 7 enable not following direction");
  level_store_a: assert property (@(posedge clk) disable iff (rst)
    lvl_write_s(0) |=> level_q[0] == $past(wb_req.dat[7:0]))
    else $error("level write not stored");
  lane_refused_a: assert property (@(posedge clk) disable iff (rst)
    req && wb_req.we && !wb_req.sel[0] |=> $stable(dir_q[2]) && $stable(level_q[2]))
    else $error("write without byte lane 0 changed a register");
  dir_read_a: assert property (@(posedge clk) disable iff (rst)
    dir_read_s(0) |=> rsp_q.ack && rsp_q.dat[7:0] == $past(dir_q[0]))
    else $error("direction read wrong");
  level_read_a: assert property (@(posedge clk) disable iff (rst)
    lvl_read_s(2) |=> rsp_q.dat[7:0] == (($past(dir_q[2]) & $past(level_q[2]))
      | (~$past(dir_q[2]) & $past(line_in[23:16], 2))))
    else $error("level read does not mix pins and stored values");

  // Pin drive
  input_no_drive_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (~$past(dir_q[0]) & out_q[7:0]) == 8'h00)
    else $error("input line driven");
  video_out_a: assert property (@(posedge clk) disable iff (rst)
    oe_q[5] |-> out_q[5] == $past(level_q[0][5]))
    else $error("video sleep line not following level");
  term_out_a: assert property (@(posedge clk) disable iff (rst)
    ##1 out_q[13:12] == ($past(level_q[1][5:4]) & $past(dir_q[1][5:4])))
    else $error("terminator lines wrong");
  kick_drive_a: assert property (@(posedge clk) disable iff (rst)
    oe_q[7] |-> out_q[7] == $past(level_q[0][7]))
    else $error("kick line not following level");
  wd_enable_drive_a: assert property (@(posedge clk) disable iff (rst)
    oe_q[14] |-> out_q[14] == $past(level_q[1][6]))
    else $error("watchdog enable line not following level");

  // Status is two edges behind the pins
  sensor_path_a: assert property (@(posedge clk) disable iff (rst)
    ##2 board_status.sensor_irq == $past(line_in[3], 2))
    else $error("sensor interrupt not two cycles behind pin");
  wd_fired_path_a: assert property (@(posedge clk) disable iff (rst)
    ##2 board_status.wd_fired_n == $past(line_in[8], 2))
    else $error("watchdog status mismatch");
  usb_path_a: assert property (@(posedge clk) disable iff (rst)
    ##2 board_status.usb_prot_ok_n == $past(line_in[10], 2))
    else $error("usb status mismatch");
  xcvr_path_a: assert property (@(posedge clk) disable iff (rst)
    ##2 board_status.xcvr_fault == $past(line_in[11], 2))
    else $error("transceiver status mismatch");
  battery_path_a: assert property (@(posedge clk) disable iff (rst)
    ##2 board_status.battery_ok == $past(line_in[30], 2))
    else $error("battery status mismatch");

endmodule

// ---- board_model.sv ----
// Board-side partner: resolves pin levels and counts watchdog restarts
`timescale 1ns/1ns
module board_model
(
  input wire logic clk,
  input wire logic [31:0] line_out,
  input wire logic [31:0] line_oe,
  input wire logic [31:0] board_drive,
  output logic [31:0] line_in,
  output int kicks,
  output logic wd_enabled
);
  logic kick_q = 1'b0;
  int count_q = 0;
  // ==========
  // Pins and supervisor
  // A released line shows the board level, never the last driven value
  assign line_in = (line_out & line_oe) | (board_drive & ~line_oe);
  assign wd_enabled = line_oe[14] & line_in[14];
  assign kicks = count_q;
  // Each flip of the kick line while driven is one restart
  always @(posedge clk)
  begin
    kick_q <= line_out[7];
    if (line_oe[7] && line_out[7] !== kick_q)
      count_q <= count_q + 1;
  end
endmodule

// ---- tb_board_gpio_ports.sv ----
// Self-checking bench for the four-port line block
`timescale 1ns/1ns
module tb_board_gpio_ports;
  import gpio_ports_pkg::*;
  logic clk;
  logic rst;
  logic er, wd_on;
  wb_req_type wb_req;
  wb_rsp_type wb_rsp;
  board_status_type board_status;
  logic [31:0] line_in, line_out, line_oe, pins, seed, rd, v;
  logic [7:0] lvl[4], dir[4], msk[4];
  int err_count, check_count, kicks, cyc_n, k;

  gpio_ports gpio_ports_i (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .board_status(board_status));
  board_model board_model_i (.clk(clk), .line_out(line_out), .line_oe(line_oe),
    .board_drive(pins), .line_in(line_in), .kicks(kicks), .wd_enabled(wd_on));

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request holds until ack or err is sampled high at a rising edge, released at that edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
    input logic [3:0] s = 4'hF);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, s, a, {24'h0, d}};
    do
      @(posedge clk);
    while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1);
    rd = wb_rsp.dat;
    er = wb_rsp.err;
    wb_req <= '0;
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      err_count++;
      close_out();
    end
  end

  // ==========
  // Scenarios
  initial
  begin
    seed = 32'h4BA3A4B0;
    err_count = 0;
    check_count = 0;
    cyc_n = 0;
    rst = 1'b1;
    wb_req = '0;
    pins = 32'h0;
    // Reserved and firmware-owned lines are never turned around by software
    msk = '{8'hA0, 8'h72, 8'hFF, 8'h80};
    dir = '{dir_reset_port0, dir_reset_port1, dir_reset_port2, dir_reset_port3};
    lvl = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(line_oe, {dir[3], dir[2], dir[1], dir[0]});
    check(line_out, 32'h0);
    check(32'(wd_on), 32'(dir[1][6] & lvl[1][6]));
    for (int p = 0; p < 4; p++)
    begin
      bus(1'b0, 10'h260 + 10'(4 * p), 8'h00);
      check(rd, 32'(dir[p]));
    end
    $display("reset test done");
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      pins <= rnd();
      for (int p = 0; p < 4; p++)
      begin
        v = rnd();
        dir[p] = v[7:0] & msk[p];
        lvl[p] = v[15:8] & msk[p];
        bus(1'b1, 10'h1E0 + 10'(4 * p), lvl[p]);
        bus(1'b1, 10'h260 + 10'(4 * p), dir[p]);
      end
      for (int p = 0; p < 4; p++)
      begin
        bus(1'b0, 10'h1E0 + 10'(4 * p), 8'h00);
        check(rd, 32'((lvl[p] & dir[p]) | (pins[8*p+:8] & ~dir[p])));
        check(32'(line_oe[8*p+:8]), 32'(dir[p]));
        check(32'(line_out[8*p+:8]), 32'(lvl[p] & dir[p]));
        bus(1'b0, 10'h260 + 10'(4 * p), 8'h00);
        check(rd, 32'(dir[p]));
      end
      check(32'(board_status), 32'({pins[3], pins[8], pins[10], pins[11],
        pins[30]}));
      check(32'(wd_on), 32'(dir[1][6] & lvl[1][6]));
    end
    $display("random test done");
    bus(1'b1, 10'h1F0, 8'hFF);
    check(32'(er), 32'h1);
    bus(1'b0, 10'h000, 8'h00);
    check(32'(er), 32'h1);
    check(line_oe, {dir[3], dir[2], dir[1], dir[0]});
    // A write without byte lane 0 is answered but leaves the register alone
    bus(1'b1, 10'h268, 8'hFF, 4'hE);
    check(32'(er), 32'h0);
    bus(1'b0, 10'h268, 8'h00);
    check(rd, 32'(dir[2]));
    $display("unmapped test done");
    dir[0] = dir[0] | 8'h80;
    bus(1'b1, 10'h260, dir[0]);
    repeat (3) @(posedge clk);
    k = kicks;
    for (int i = 0; i < 4; i++)
    begin
      lvl[0][7] = ~lvl[0][7];
      bus(1'b1, 10'h1E0, lvl[0]);
    end
    repeat (3) @(posedge clk);
    check(32'(kicks - k), 32'h4);
    $display("kick test done");
    close_out();
  end
endmodule
